// [common/sur_pkg.sv]
// Register map constants for the synthesizer upper readback register bank.
`default_nettype none
package sur_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index).
  localparam logic [6:0] IDX_RSVD_A = 7'h66;
  localparam logic [6:0] IDX_RSVD_B = 7'h67;
  localparam logic [6:0] IDX_RSVD_C = 7'h68;
  localparam logic [6:0] IDX_RSVD_D = 7'h69;
  localparam logic [6:0] IDX_RSVD_E = 7'h6a;
  localparam logic [6:0] IDX_UNUSED_A = 7'h6b;
  localparam logic [6:0] IDX_UNUSED_B = 7'h6c;
  localparam logic [6:0] IDX_UNUSED_C = 7'h6d;
  localparam logic [6:0] IDX_LOCK_CORE = 7'h6e;
  localparam logic [6:0] IDX_CAP_TRIM = 7'h6f;
  localparam logic [6:0] IDX_BIAS_DAC = 7'h70;
  localparam logic [6:0] IDX_UNUSED_D = 7'h71;
  localparam logic [6:0] IDX_RSVD_F = 7'h72;
  // ==========================================================
  // Reset values.
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_RSVD_D = 16'h0440;
  localparam logic [15:0] RST_RSVD_E = 16'h0007;
  // ==========================================================
  // Field positions.
  localparam int LOCK_LSB = 9;
  localparam int CORE_LSB = 5;
  // Lock state encodings.
  localparam logic [1:0] LOCK_UNLOCKED_LOW = 2'h0;
  localparam logic [1:0] LOCK_INVALID = 2'h1;
  localparam logic [1:0] LOCK_LOCKED = 2'h2;
  localparam logic [1:0] LOCK_UNLOCKED_HIGH = 2'h3;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sur_pkg
`default_nettype wire

// [rtl/sur_upper_regs.sv]
// AXI4-Lite register bank for the synthesizer upper readback registers.
`default_nettype none
// Notes on behaviour
// R1: Reserved words 0x66, 0x67, 0x68, 0x72 reset to zero; host writes zero.
// R2: Reserved word 0x69 resets to 0x440; host writes zero.
// R3: Reserved word 0x6A resets to 0x7; host writes zero.
// R4: Unused words and unused status bits read as zero.
// R5: Bits 10-9 at 0x6E report lock state: low, invalid, locked, high.
// R6: Bits 7-5 at 0x6E report the core chosen by calibration.
// R7: Bits 7-0 at 0x6F report the calibrated capacitor trim code.
// R8: Bits 8-0 at 0x70 report the calibrated bias DAC code.
// R9: Writes to read-only words ignored; readbacks follow calibration, lock.
module sur_upper_regs (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [8:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [8:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic calDone,
  input wire logic [2:0] calCore,
  input wire logic [7:0] calCapTrim,
  input wire logic [8:0] calBiasDac,
  input wire logic [1:0] lockState
);

  // ==========================================================
  // Write channel.
  logic awHeld;
  logic wHeld;
  logic [6:0] awIdx;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic [15:0] rsvdWord [6];
  logic [15:0] rsvdReset [6];
  logic [2:0] wSel;
  logic wHit;

  // Tells whether a word index lies inside the mapped window.
  function automatic logic rdMapped(input logic [6:0] idx);
    rdMapped = (idx >= sur_pkg::IDX_RSVD_A) && (idx <= sur_pkg::IDX_RSVD_F);
  endfunction : rdMapped

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      awHeld <= 1'b0;
      awIdx <= 7'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awIdx <= s_axi_awaddr[8:2];
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  // Maps a word index onto one of the six writable reserved words.
  always_comb begin
    wHit = 1'b1;
    wSel = 3'd0;
    unique case (awIdx)
      sur_pkg::IDX_RSVD_A: wSel = 3'd0;
      sur_pkg::IDX_RSVD_B: wSel = 3'd1;
      sur_pkg::IDX_RSVD_C: wSel = 3'd2;
      sur_pkg::IDX_RSVD_D: wSel = 3'd3;
      sur_pkg::IDX_RSVD_E: wSel = 3'd4;
      sur_pkg::IDX_RSVD_F: wSel = 3'd5;
      default: wHit = 1'b0;
    endcase
  end

  assign rsvdReset[0] = sur_pkg::RST_ZERO; // R1
  assign rsvdReset[1] = sur_pkg::RST_ZERO; // R1
  assign rsvdReset[2] = sur_pkg::RST_ZERO; // R1
  assign rsvdReset[3] = sur_pkg::RST_RSVD_D; // R2
  assign rsvdReset[4] = sur_pkg::RST_RSVD_E; // R3
  assign rsvdReset[5] = sur_pkg::RST_ZERO; // R1

  // Reserved words store what is written, byte by byte.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rsvdWord[0] <= sur_pkg::RST_ZERO; // R1
      rsvdWord[1] <= sur_pkg::RST_ZERO; // R1
      rsvdWord[2] <= sur_pkg::RST_ZERO; // R1
      rsvdWord[3] <= sur_pkg::RST_RSVD_D; // R2
      rsvdWord[4] <= sur_pkg::RST_RSVD_E; // R3
      rsvdWord[5] <= sur_pkg::RST_ZERO; // R1
    end else if (doWrite && wHit) begin
      if (wStrb[0]) begin
        rsvdWord[wSel][7:0] <= wData[7:0];
      end
      if (wStrb[1]) begin
        rsvdWord[wSel][15:8] <= wData[15:8];
      end
    end
  end

  // Writes to read-only words are answered but change nothing.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sur_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wHit || rdMapped(awIdx)) ? sur_pkg::RESP_OKAY
                     : sur_pkg::RESP_SLVERR; // R9
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Status capture.
  logic [1:0] lockStatus;
  logic [2:0] coreStatus;
  logic [7:0] capStatus;
  logic [8:0] biasStatus;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lockStatus <= sur_pkg::LOCK_UNLOCKED_LOW;
    end else if (lockState != lockStatus) begin
      lockStatus <= lockState; // R5 R9
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      coreStatus <= 3'h0;
      capStatus <= 8'h00;
      biasStatus <= 9'h000;
    end else if (calDone) begin
      coreStatus <= calCore; // R6 R9
      capStatus <= calCapTrim; // R7
      biasStatus <= calBiasDac; // R8
    end
  end

  // ==========================================================
  // Read channel.
  logic [15:0] rdWord;
  logic [6:0] arIdx;

  assign arIdx = s_axi_araddr[8:2];
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rdWord = 16'h0000; // R4
    unique case (arIdx)
      sur_pkg::IDX_RSVD_A: rdWord = rsvdWord[0];
      sur_pkg::IDX_RSVD_B: rdWord = rsvdWord[1];
      sur_pkg::IDX_RSVD_C: rdWord = rsvdWord[2];
      sur_pkg::IDX_RSVD_D: rdWord = rsvdWord[3];
      sur_pkg::IDX_RSVD_E: rdWord = rsvdWord[4];
      sur_pkg::IDX_RSVD_F: rdWord = rsvdWord[5];
      sur_pkg::IDX_LOCK_CORE: begin
        rdWord[sur_pkg::LOCK_LSB +: 2] = lockStatus; // R5
        rdWord[sur_pkg::CORE_LSB +: 3] = coreStatus; // R6
      end
      sur_pkg::IDX_CAP_TRIM: rdWord[7:0] = capStatus; // R7
      sur_pkg::IDX_BIAS_DAC: rdWord[8:0] = biasStatus; // R8
      default: rdWord = 16'h0000; // R4
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sur_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rdWord};
      s_axi_rresp <= rdMapped(arIdx) ? sur_pkg::RESP_OKAY
                     : sur_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic unusedBits;
  assign unusedBits = ^{wData[31:16], wStrb[3:2], rsvdReset[0],
                        rsvdReset[1], rsvdReset[2], rsvdReset[3],
                        rsvdReset[4], rsvdReset[5]};

endmodule : sur_upper_regs
`default_nettype wire

// [test/sur_upper_regs_asserts.sv]
// Checker of the upper readback register bank.
`default_nettype none
module sur_upper_regs_asserts (
  input wire logic sys_clk, reset, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready, s_axi_bvalid,
  input wire logic s_axi_awready, s_axi_wready,
  input wire logic [8:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp, lockState
);
  // ==========
  // Read index tracking and port properties.
  logic [6:0] ix;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge sys_clk) begin
    if (s_axi_arvalid && s_axi_arready) ix <= s_axi_araddr[8:2];
  end
  a_read_next:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_once:
  assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  a_upper_zero:
  assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper data not zero");
  a_lock_field:
  assert property ($rose(s_axi_rvalid) && ix == 7'h6e |-> s_axi_rdata[15:0]
    == {5'h0, $past(lockState, 2), 1'b0, s_axi_rdata[7:5], 5'h0})
    else $error("lock word wrong");
  a_status_pad:
  assert property (s_axi_rvalid && ix inside {7'h6f, 7'h70} |->
    s_axi_rdata[15:9] == 7'h0 && (ix == 7'h70 || !s_axi_rdata[8]))
    else $error("status pad not zero");
  a_unused_zero:
  assert property (s_axi_rvalid && ix inside {[7'h6b:7'h6d], 7'h71} |->
    s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0)
    else $error("unused word not zero");
  a_bad_slverr:
  assert property (s_axi_rvalid && (ix < 7'h66 || ix > 7'h72) |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  a_wr_refuse:
  assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  cover property (s_axi_rvalid && ix == 7'h6e && s_axi_rdata[10:9] == 2'h2);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (s_axi_bvalid);
endmodule : sur_upper_regs_asserts
bind sur_upper_regs sur_upper_regs_asserts u_sur_upper_regs_asserts (.*);
`default_nettype wire

// [test/sur_upper_regs_tb.sv]
// Bench for the upper readback register bank.
`default_nettype none
module sur_upper_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Bus master, expectation queue and checks.
  logic sys_clk = 0, reset = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, calDone = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [8:0] s_axi_awaddr = 0, s_axi_araddr = 0, calBiasDac = 0, bs = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, seed = 32'h000067f9;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic [1:0] s_axi_bresp, s_axi_rresp, lockState = 0, lk = 0;
  logic [2:0] calCore = 0, cr = 0;
  logic [7:0] calCapTrim = 0, cp = 0;
  logic [6:0] i;
  logic [15:0] rs [7'h66:7'h72];
  logic [33:0] q [$];
  int c, n_errors = 0, total_checks = 0;
  sur_upper_regs u_sur_upper_regs (.*);
  always #5 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [33:0] ex(input logic [6:0] k);
    if (k < 7'h66 || k > 7'h72) return {2'h2, 32'h0};
    case (k)
      7'h6b, 7'h6c, 7'h6d, 7'h71: return 34'h0;
      7'h6e: return {23'h0, lk, 1'b0, cr, 5'h0};
      7'h6f: return {26'h0, cp};
      7'h70: return {25'h0, bs};
      default: return {18'h0, rs[k]};
    endcase
  endfunction : ex
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED resp_data expected %h seen %h", e, s);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic xfer(input logic wr, input logic [6:0] k,
    input logic [31:0] w, input logic [33:0] e);
    int n;
    q.push_back(e);
    @(posedge sys_clk);
    s_axi_awaddr <= {k, 2'h0};
    s_axi_araddr <= {k, 2'h0};
    s_axi_wdata <= w;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (n == 50) begin
      n_errors++;
      report_and_stop();
    end
  endtask : xfer
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      chk({s_axi_bresp, 32'h0}, q.pop_front());
    end
  end
  initial begin
    foreach (rs[k]) rs[k] = 16'h0;
    rs[7'h69] = 16'h0440;
    rs[7'h6a] = 16'h0007;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    for (i = 7'h65; i <= 7'h73; i++) xfer(0, i, 0, ex(i));
    for (c = 0; c < 2; c++) begin
      for (i = 7'h65; i <= 7'h73; i++) begin
        d = (c || i inside {[7'h66:7'h6a], 7'h72}) ? 32'h0 : rnd();
        xfer(1, i, d, {(i < 7'h66 || i > 7'h72) ? 2'h2 : 2'h0, 32'h0});
        if (i inside {[7'h66:7'h6a], 7'h72}) rs[i] = d[15:0];
        xfer(0, i, 0, ex(i));
      end
    end
    for (c = 0; c < 4; c++) begin
      @(posedge sys_clk);
      lockState <= c[1:0];
      lk = c[1:0];
      xfer(0, 7'h6e, 0, ex(7'h6e));
    end
    for (c = 1; c < 8; c++) begin
      d = rnd();
      @(posedge sys_clk);
      {calDone, calCore, calCapTrim, calBiasDac} <= {1'b1, c[2:0], d[16:0]};
      {cr, cp, bs} = {c[2:0], d[16:0]};
      d = rnd();
      @(posedge sys_clk);
      {calDone, calCore, calCapTrim, calBiasDac} <= {1'b0, d[19:0]};
      for (i = 7'h6e; i <= 7'h70; i++) xfer(0, i, 0, ex(i));
    end
    report_and_stop();
  end
endmodule : sur_upper_regs_tb
`default_nettype wire
